// ==== tcs_pkg.sv ====
`default_nettype none
package tcs_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h8e;
	localparam logic [7:0] ADDR_T2_CTRL = 8'hc8;
	localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'hca;
	localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'hcc;
	localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'hcd;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Clock-control field positions
	localparam int POS_T3_HIGH_SEL = 7;
	localparam int POS_T3_LOW_SEL = 6;
	localparam int POS_T2_HIGH_SEL = 5;
	localparam int POS_T2_LOW_SEL = 4;
	localparam int POS_T1_SEL = 3;
	localparam int POS_T0_SEL = 2;
	localparam int POS_PRESCALE = 0;

	// Timer-two control field positions; bit 1 reads zero
	localparam int POS_T2_HIGH_FLAG = 7;
	localparam int POS_T2_LOW_FLAG = 6;
	localparam int POS_T2_LOW_IRQ_EN = 5;
	localparam int POS_T2_CAPTURE_EN = 4;
	localparam int POS_T2_SPLIT = 3;
	localparam int POS_T2_RUN = 2;
	localparam int POS_T2_EXT_SEL = 0;

	// Prescale encodings
	localparam logic [1:0] PRE_DIV12 = 2'h0;
	localparam logic [1:0] PRE_DIV4 = 2'h1;
	localparam logic [1:0] PRE_DIV48 = 2'h2;
	localparam logic [1:0] PRE_EXT8 = 2'h3;

	// Division ratios in system-clock or external-clock edges
	localparam int DIV_4 = 4;
	localparam int DIV_12 = 12;
	localparam int DIV_48 = 48;
	localparam int DIV_EXT = 8;

	typedef struct packed {
		logic third_timer_high_clk_sel;
		logic third_timer_low_clk_sel;
		logic timer_two_high_clk_sel;
		logic timer_two_low_clk_sel;
		logic timer_one_clk_sel;
		logic timer_zero_clk_sel;
		logic [1:0] prescale_select;
	} tcs_clk_ctrl_t;

	typedef struct packed {
		logic timer_two_high_overflow_flag;
		logic timer_two_low_overflow_flag;
		logic timer_two_low_irq_enable;
		logic timer_two_capture_enable;
		logic timer_two_split_mode;
		logic timer_two_run;
		logic unused;
		logic timer_two_ext_clk_sel;
	} tcs_t2_ctrl_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} tcs_sfr_req_t;
endpackage
`default_nettype wire

// ==== tcs_timer_clock.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Third-timer high half in split mode: 1 system clock, 0 external-select choice.
// - Third-timer low select: 1 system clock, 0 external-select choice.
// - Second-timer high half in split mode: 1 system clock, 0 external-select choice.
// - Second-timer low select clocks whole timer or low half; 1 system clock.
// - Timer one: select 1 system clock, 0 prescaled; ignored in pin-counter mode.
// - Timer zero: select 1 system clock, 0 prescaled; ignored in pin-counter mode.
// - Prescale field: 00 div 12, 01 div 4, 10 div 48, 11 external div 8.
// - External divided-by-8 clock is synchronized to system clock before use.
// - Timers zero and one each have readable, writable low and high bytes.
// - Second timer has two byte counters; split bit picks 16-bit or two 8-bit.
// - 16-bit wrap from all ones loads reload pair and sets high overflow flag.
// - 16-bit mode with interrupt enable requests interrupt on each full overflow.
// - With low-byte enable too, low byte wrap also requests an interrupt.
// - Split mode halves reload independently from their own reload registers.
// - Split mode run bit gates only high half; low half always counts.
// - Split half: select 1 system clock, else div 12 or external div 8.
// - Split mode sets high or low overflow flag on that half's wrap.
// - Split interrupt on high overflow; with low enable, on either half.
// - Overflow flags are never cleared by hardware, only by software writes.
module tcs_timer_clock (
	input wire logic clk_sys,
	input wire logic srst,
	input wire tcs_pkg::tcs_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic ext_clk,
	input wire logic timer_two_irq_enable,
	input wire logic timer_zero_counter_mode,
	input wire logic timer_one_counter_mode,
	input wire logic third_timer_split_mode,
	input wire logic third_timer_ext_clk_sel,
	output logic timer_zero_tick,
	output logic timer_one_tick,
	output logic third_timer_low_tick,
	output logic third_timer_high_tick,
	output logic timer_two_irq
);
	import tcs_pkg::*;

	// Byte-select clock choice: system clock or the external-select choice
	function automatic logic pick_tick(input logic sys_sel, input logic ext_sel,
		input logic div12, input logic ext8);
		pick_tick = sys_sel ? 1'b1 : (ext_sel ? ext8 : div12);
	endfunction

	function automatic logic hit(input tcs_sfr_req_t r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	tcs_clk_ctrl_t clk_ctrl;
	tcs_t2_ctrl_t t2_ctrl;
	logic [7:0] t01_byte [4];
	logic [7:0] t2_reload_low;
	logic [7:0] t2_reload_high;
	logic [7:0] t2_count_low;
	logic [7:0] t2_count_high;
	logic [5:0] pre_cnt;
	logic ext_sync1;
	logic ext_sync2;
	logic ext_prev;
	logic [2:0] ext_cnt;
	logic ext8_tick;
	logic div4_tick;
	logic div12_tick;
	logic div48_tick;
	logic prescaled;
	logic t2_low_en;
	logic t2_high_en;
	logic low_wrap;
	logic high_wrap;
	logic full_wrap;
	logic next_irq;

	localparam logic [5:0] PRE_LAST = 6'(DIV_48 - 1);
	localparam logic [2:0] EXT_LAST = 3'(DIV_EXT - 1);
	localparam logic [7:0] BYTE_MAX = 8'hff;

	// Two-flop synchroniser; only the second flop feeds the edge detector
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ext_sync1 <= 1'b0;
			ext_sync2 <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_sync1 <= ext_clk;
			ext_sync2 <= ext_sync1;
			ext_prev <= ext_sync2;
		end
	end

	// Every eighth rising external edge gives one enable pulse
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ext_cnt <= 3'h0;
			ext8_tick <= 1'b0;
		end else begin
			ext8_tick <= 1'b0;
			if (ext_sync2 && !ext_prev) begin
				ext_cnt <= ext_cnt + 3'h1;
				ext8_tick <= (ext_cnt == EXT_LAST);
			end
		end
	end

	// One counter serves all three system-clock ratios, since 4 and 12 divide 48
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pre_cnt <= 6'h00;
		end else if (pre_cnt == PRE_LAST) begin
			pre_cnt <= 6'h00;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
		end
	end

	always_comb begin
		div4_tick = (pre_cnt % 6'(DIV_4)) == 6'(DIV_4 - 1);
		div12_tick = (pre_cnt % 6'(DIV_12)) == 6'(DIV_12 - 1);
		div48_tick = (pre_cnt == PRE_LAST);
		case (clk_ctrl.prescale_select)
			PRE_DIV12: prescaled = div12_tick;
			PRE_DIV4: prescaled = div4_tick;
			PRE_DIV48: prescaled = div48_tick;
			PRE_EXT8: prescaled = ext8_tick;
			default: prescaled = 1'b0;
		endcase
	end

	// Timer zero/one count enables; pin-counter mode counts elsewhere
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_zero_tick <= 1'b0;
			timer_one_tick <= 1'b0;
		end else begin
			timer_zero_tick <= !timer_zero_counter_mode &&
				(clk_ctrl.timer_zero_clk_sel || prescaled);
			timer_one_tick <= !timer_one_counter_mode &&
				(clk_ctrl.timer_one_clk_sel || prescaled);
		end
	end

	// Third-timer enables; high half idles unless split
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			third_timer_low_tick <= 1'b0;
			third_timer_high_tick <= 1'b0;
		end else begin
			third_timer_low_tick <= pick_tick(clk_ctrl.third_timer_low_clk_sel,
				third_timer_ext_clk_sel, div12_tick, ext8_tick);
			third_timer_high_tick <= third_timer_split_mode &&
				pick_tick(clk_ctrl.third_timer_high_clk_sel,
				third_timer_ext_clk_sel, div12_tick, ext8_tick);
		end
	end

	// Clock control register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			clk_ctrl <= tcs_clk_ctrl_t'(RST_BYTE);
		end else if (hit(sfr_req, ADDR_CLK_CTRL)) begin
			clk_ctrl <= tcs_clk_ctrl_t'(sfr_req.wdata);
		end
	end

	// Timer zero/one byte registers; counting is done elsewhere
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < 4; i++) begin
				t01_byte[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (hit(sfr_req, ADDR_T0_LOW + 8'(i))) begin
					t01_byte[i] <= sfr_req.wdata;
				end
			end
		end
	end

	// Timer-two clock enables, combinational so counting is not delayed
	always_comb begin
		// low byte (or whole timer) source
		t2_low_en = pick_tick(clk_ctrl.timer_two_low_clk_sel,
			t2_ctrl.timer_two_ext_clk_sel, div12_tick, ext8_tick);
		// high select honoured only when split
		t2_high_en = pick_tick(clk_ctrl.timer_two_high_clk_sel,
			t2_ctrl.timer_two_ext_clk_sel, div12_tick, ext8_tick);
		if (t2_ctrl.timer_two_split_mode) begin
			t2_high_en = t2_high_en && t2_ctrl.timer_two_run;
			low_wrap = t2_low_en && (t2_count_low == BYTE_MAX);
			high_wrap = t2_high_en && (t2_count_high == BYTE_MAX);
			full_wrap = 1'b0;
		end else begin
			t2_low_en = t2_low_en && t2_ctrl.timer_two_run;
			t2_high_en = 1'b0;
			low_wrap = t2_low_en && (t2_count_low == BYTE_MAX);
			full_wrap = low_wrap && (t2_count_high == BYTE_MAX);
			high_wrap = full_wrap;
		end
	end

	// Timer-two counters; a software write wins over counting
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			t2_count_low <= RST_BYTE;
			t2_count_high <= RST_BYTE;
		end else begin
			if (hit(sfr_req, ADDR_T2_COUNT_LOW)) begin
				t2_count_low <= sfr_req.wdata;
			end else if (full_wrap) begin
				t2_count_low <= t2_reload_low;
			end else if (low_wrap && t2_ctrl.timer_two_split_mode) begin
				t2_count_low <= t2_reload_low;
			end else if (t2_low_en) begin
				t2_count_low <= t2_count_low + 8'h01;
			end
			if (hit(sfr_req, ADDR_T2_COUNT_HIGH)) begin
				t2_count_high <= sfr_req.wdata;
			end else if (high_wrap) begin
				t2_count_high <= t2_reload_high;
			end else if (t2_ctrl.timer_two_split_mode ? t2_high_en : low_wrap) begin
				t2_count_high <= t2_count_high + 8'h01;
			end
		end
	end

	// Reload registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			t2_reload_low <= RST_BYTE;
			t2_reload_high <= RST_BYTE;
		end else begin
			if (hit(sfr_req, ADDR_T2_RELOAD_LOW)) begin
				t2_reload_low <= sfr_req.wdata;
			end
			if (hit(sfr_req, ADDR_T2_RELOAD_HIGH)) begin
				t2_reload_high <= sfr_req.wdata;
			end
		end
	end

	// Control register; an overflow in the clearing cycle still sets its flag
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			t2_ctrl <= tcs_t2_ctrl_t'(RST_BYTE);
		end else begin
			if (hit(sfr_req, ADDR_T2_CTRL)) begin
				t2_ctrl <= tcs_t2_ctrl_t'(sfr_req.wdata);
				t2_ctrl.unused <= 1'b0;
			end
			if (high_wrap) begin
				t2_ctrl.timer_two_high_overflow_flag <= 1'b1;
			end
			if (low_wrap) begin
				t2_ctrl.timer_two_low_overflow_flag <= 1'b1;
			end
		end
	end

	// Level request, held while a qualifying flag stays set
	always_comb begin
		next_irq = timer_two_irq_enable &&
			(t2_ctrl.timer_two_high_overflow_flag ||
			(t2_ctrl.timer_two_low_irq_enable &&
			t2_ctrl.timer_two_low_overflow_flag));
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_two_irq <= 1'b0;
		end else begin
			timer_two_irq <= next_irq;
		end
	end

	// Registered read data: address sampled every cycle, unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sfr_rdata <= RST_BYTE;
		end else begin
			case (sfr_req.addr)
				ADDR_T0_LOW: sfr_rdata <= t01_byte[0];
				ADDR_T1_LOW: sfr_rdata <= t01_byte[1];
				ADDR_T0_HIGH: sfr_rdata <= t01_byte[2];
				ADDR_T1_HIGH: sfr_rdata <= t01_byte[3];
				ADDR_CLK_CTRL: sfr_rdata <= clk_ctrl;
				ADDR_T2_CTRL: sfr_rdata <= t2_ctrl;
				ADDR_T2_RELOAD_LOW: sfr_rdata <= t2_reload_low;
				ADDR_T2_RELOAD_HIGH: sfr_rdata <= t2_reload_high;
				ADDR_T2_COUNT_LOW: sfr_rdata <= t2_count_low;
				ADDR_T2_COUNT_HIGH: sfr_rdata <= t2_count_high;
				default: sfr_rdata <= RST_BYTE;
			endcase
		end
	end

	a_sys_select_t0: assert property (@(posedge clk_sys) disable iff (srst)
		(clk_ctrl.timer_zero_clk_sel && !timer_zero_counter_mode) |=> timer_zero_tick)
		else $error("timer zero missed system-clock tick");

	a_pin_mode_t1: assert property (@(posedge clk_sys) disable iff (srst)
		timer_one_counter_mode |=> !timer_one_tick)
		else $error("timer one ticked in pin-counter mode");

	a_div48_spacing: assert property (@(posedge clk_sys) disable iff (srst)
		div48_tick |=> !div48_tick [*8])
		else $error("divide by 48 pulse too close");

	a_prescale_div4: assert property (@(posedge clk_sys) disable iff (srst)
		(clk_ctrl.prescale_select == PRE_DIV4 && $stable(clk_ctrl) && prescaled)
		|-> ##4 (prescaled || clk_ctrl != $past(clk_ctrl, 4)))
		else $error("divide by 4 period wrong");

	a_ext_pulse_single: assert property (@(posedge clk_sys) disable iff (srst)
		ext8_tick |=> !ext8_tick)
		else $error("external tick longer than one cycle");

	a_full_reload: assert property (@(posedge clk_sys) disable iff (srst)
		(full_wrap && !sfr_req.wr) |=>
		(t2_count_low == $past(t2_reload_low) && t2_count_high == $past(t2_reload_high)
		&& t2_ctrl.timer_two_high_overflow_flag))
		else $error("16-bit overflow did not reload");

	a_split_low_runs: assert property (@(posedge clk_sys) disable iff (srst)
		(t2_ctrl.timer_two_split_mode && clk_ctrl.timer_two_low_clk_sel && !sfr_req.wr)
		|=> t2_count_low != $past(t2_count_low))
		else $error("split low half stalled");

	a_split_high_gated: assert property (@(posedge clk_sys) disable iff (srst)
		(t2_ctrl.timer_two_split_mode && !t2_ctrl.timer_two_run && !sfr_req.wr)
		|=> $stable(t2_count_high))
		else $error("split high half counted while stopped");

	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (srst)
		(t2_ctrl.timer_two_low_overflow_flag && !hit(sfr_req, ADDR_T2_CTRL))
		|=> t2_ctrl.timer_two_low_overflow_flag)
		else $error("low overflow flag cleared by hardware");

	a_irq_follows: assert property (@(posedge clk_sys) disable iff (srst)
		next_irq |=> timer_two_irq)
		else $error("interrupt request not raised");

	a_t3_high_idle: assert property (@(posedge clk_sys) disable iff (srst)
		!third_timer_split_mode |=> !third_timer_high_tick)
		else $error("third timer high ticked outside split mode");
endmodule
`default_nettype wire

// ==== tcs_timer_clock_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_timer_clock_bench;
	import tcs_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	tcs_sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic ext_clk = 1'b0;
	logic [1:0] ext_cnt = 2'h0;
	logic t2_irq_en = 1'b1;
	logic t0_pin = 1'b0;
	logic t1_pin = 1'b0;
	logic t3_split = 1'b0;
	logic t3_ext = 1'b0;
	logic t0_tick;
	logic t1_tick;
	logic t3_low_tick;
	logic t3_high_tick;
	logic t2_irq;
	int miscompares = 0;
	int tests_run = 0;
	logic [7:0] rd;

	tcs_timer_clock tcs_timer_clock_inst (
		.clk_sys(clk_sys),
		.srst(srst),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.ext_clk(ext_clk),
		.timer_two_irq_enable(t2_irq_en),
		.timer_zero_counter_mode(t0_pin),
		.timer_one_counter_mode(t1_pin),
		.third_timer_split_mode(t3_split),
		.third_timer_ext_clk_sel(t3_ext),
		.timer_zero_tick(t0_tick),
		.timer_one_tick(t1_tick),
		.third_timer_low_tick(t3_low_tick),
		.third_timer_high_tick(t3_high_tick),
		.timer_two_irq(t2_irq)
	);

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	// External source with a period of four system cycles
	always @(posedge clk_sys) begin
		ext_cnt <= ext_cnt + 2'h1;
		ext_clk <= ext_cnt[1];
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
		@(posedge clk_sys);
		sfr_req.wr <= 1'b0;
	endtask

	// Read data is registered: it follows the address by one edge
	task automatic rdb(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		sfr_req <= '{addr: a, wr: 1'b0, wdata: 8'h00};
		@(posedge clk_sys);
		#1 d = sfr_rdata;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rdb(a, d);
		check(what, {8'h00, d}, {8'h00, exp});
	endtask

	task automatic count(input int cycles, output int n0, output int n1, output int nl,
			output int nh);
		n0 = 0;
		n1 = 0;
		nl = 0;
		nh = 0;
		repeat (cycles) begin
			@(posedge clk_sys);
			#1;
			n0 += int'(t0_tick === 1'b1);
			n1 += int'(t1_tick === 1'b1);
			nl += int'(t3_low_tick === 1'b1);
			nh += int'(t3_high_tick === 1'b1);
		end
	endtask

	task automatic wait_irq(input logic lvl);
		int i;
		// Step off the edge so the request is seen after it settles
		#1;
		for (i = 0; i < 2000 && t2_irq !== lvl; i++) begin
			cyc(1);
		end
		if (i == 2000) begin
			miscompares++;
			$display("FAIL irq wait expected %h seen %h", lvl, t2_irq);
			test_done;
		end
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(2);
	endtask

	task automatic t_regs;
		logic [7:0] a[10] = '{ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH, ADDR_T1_HIGH, ADDR_CLK_CTRL,
			ADDR_T2_CTRL, ADDR_T2_RELOAD_LOW, ADDR_T2_RELOAD_HIGH, ADDR_T2_COUNT_LOW,
			ADDR_T2_COUNT_HIGH};
		for (int i = 0; i < 10; i++) begin
			rchk("reset value", a[i], RST_BYTE);
		end
		for (int i = 0; i < 5; i++) begin
			wr(a[i], 8'ha5 ^ 8'(i));
		end
		for (int i = 0; i < 5; i++) begin
			rchk("byte readback", a[i], 8'ha5 ^ 8'(i));
		end
		rchk("unmapped", 8'hc9, 8'h00);
		wr(ADDR_T2_CTRL, 8'h02);
		rchk("unused bit", ADDR_T2_CTRL, 8'h00);
		wr(ADDR_CLK_CTRL, 8'h00);
		$display("register test done");
	endtask

	task automatic t_clocks;
		int divs[3] = '{DIV_12, DIV_4, DIV_48};
		int n0;
		int n1;
		int nl;
		int nh;
		for (int p = 0; p < 3; p++) begin
			wr(ADDR_CLK_CTRL, 8'(p));
			cyc(4);
			count(96, n0, n1, nl, nh);
			check("t0 prescaled", 16'(n0), 16'(96 / divs[p]));
			check("t1 prescaled", 16'(n1), 16'(96 / divs[p]));
		end
		wr(ADDR_CLK_CTRL, 8'h0c);
		cyc(4);
		count(96, n0, n1, nl, nh);
		check("t0 system", 16'(n0), 16'd96);
		check("t1 system", 16'(n1), 16'd96);
		@(posedge clk_sys);
		t0_pin <= 1'b1;
		t1_pin <= 1'b1;
		cyc(4);
		count(96, n0, n1, nl, nh);
		check("t0 pin mode", 16'(n0), 16'd0);
		check("t1 pin mode", 16'(n1), 16'd0);
		@(posedge clk_sys);
		t0_pin <= 1'b0;
		t1_pin <= 1'b0;
		wr(ADDR_CLK_CTRL, 8'h03);
		cyc(8);
		count(320, n0, n1, nl, nh);
		check("t0 external", 16'(n0 >= 9 && n0 <= 11), 16'd1);
		check("t1 external", 16'(n1), 16'(n0));
		@(posedge clk_sys);
		t3_split <= 1'b1;
		wr(ADDR_CLK_CTRL, 8'h40);
		cyc(4);
		count(96, n0, n1, nl, nh);
		check("t3 low system", 16'(nl), 16'd96);
		check("t3 high div12", 16'(nh), 16'd8);
		@(posedge clk_sys);
		t3_ext <= 1'b1;
		wr(ADDR_CLK_CTRL, 8'h80);
		cyc(8);
		count(96, n0, n1, nl, nh);
		check("t3 high system", 16'(nh), 16'd96);
		check("t3 low external", 16'(nl >= 2 && nl <= 4), 16'd1);
		$display("clock select test done");
	endtask

	// Whole timer two on its external-select choice: low select is 0 here
	task automatic t_t2_source;
		logic [7:0] d;
		wr(ADDR_T2_CTRL, 8'h00);
		wr(ADDR_T2_COUNT_LOW, 8'h00);
		wr(ADDR_T2_CTRL, 8'h04);
		cyc(120);
		rdb(ADDR_T2_COUNT_LOW, d);
		check("t2 div12 count", 16'(d >= 8'd9 && d <= 8'd11), 16'h1);
		wr(ADDR_T2_CTRL, 8'h01);
		wr(ADDR_T2_COUNT_LOW, 8'h00);
		wr(ADDR_T2_CTRL, 8'h05);
		cyc(320);
		rdb(ADDR_T2_COUNT_LOW, d);
		check("t2 ext8 count", 16'(d >= 8'd9 && d <= 8'd11), 16'h1);
		wr(ADDR_T2_CTRL, 8'h00);
		$display("timer two source test done");
	endtask

	task automatic t_wide;
		do_reset;
		wr(ADDR_CLK_CTRL, 8'h10);
		wr(ADDR_T2_RELOAD_HIGH, 8'h12);
		wr(ADDR_T2_COUNT_LOW, 8'hfe);
		wr(ADDR_T2_COUNT_HIGH, 8'hff);
		wr(ADDR_T2_CTRL, 8'h04);
		wait_irq(1'b1);
		cyc(20);
		rchk("wide flags", ADDR_T2_CTRL, 8'hc4);
		rchk("wide reload", ADDR_T2_COUNT_HIGH, 8'h12);
		wr(ADDR_T2_CTRL, 8'h04);
		cyc(3);
		check("irq after clear", {15'h0, t2_irq}, 16'h0);
		wr(ADDR_T2_CTRL, 8'h24);
		wait_irq(1'b1);
		rchk("low wrap flags", ADDR_T2_CTRL, 8'h64);
		wr(ADDR_T2_CTRL, 8'h00);
		$display("wide mode test done");
	endtask

	task automatic t_split;
		do_reset;
		wr(ADDR_CLK_CTRL, 8'h10);
		wr(ADDR_T2_RELOAD_LOW, 8'h80);
		wr(ADDR_T2_RELOAD_HIGH, 8'h40);
		wr(ADDR_T2_COUNT_HIGH, 8'h33);
		wr(ADDR_T2_COUNT_LOW, 8'hf0);
		wr(ADDR_T2_CTRL, 8'h08);
		cyc(40);
		rchk("split low flag", ADDR_T2_CTRL, 8'h48);
		check("irq low only", {15'h0, t2_irq}, 16'h0);
		rchk("high stopped", ADDR_T2_COUNT_HIGH, 8'h33);
		rdb(ADDR_T2_COUNT_LOW, rd);
		check("low reloaded", {15'h0, rd[7]}, 16'h1);
		// Flag bit written as one so the pending flag is kept
		wr(ADDR_T2_CTRL, 8'h68);
		wait_irq(1'b1);
		@(posedge clk_sys);
		t2_irq_en <= 1'b0;
		cyc(3);
		check("irq enable drop", {15'h0, t2_irq}, 16'h0);
		@(posedge clk_sys);
		t2_irq_en <= 1'b1;
		wr(ADDR_T2_COUNT_HIGH, 8'hfe);
		wr(ADDR_CLK_CTRL, 8'h30);
		wr(ADDR_T2_CTRL, 8'h0c);
		cyc(4);
		rdb(ADDR_T2_COUNT_HIGH, rd);
		check("high reload", {12'h0, rd[7:4]}, 16'h4);
		rdb(ADDR_T2_CTRL, rd);
		check("high flag", {15'h0, rd[7]}, 16'h1);
		check("irq high", {15'h0, t2_irq}, 16'h1);
		// Software clears both flags itself after finding the source
		wr(ADDR_T2_CTRL, 8'h08);
		cyc(3);
		check("irq after clear", {15'h0, t2_irq}, 16'h0);
		rdb(ADDR_T2_CTRL, rd);
		check("high flag cleared", {15'h0, rd[7]}, 16'h0);
		$display("split mode test done");
	endtask

	initial begin
		do_reset;
		t_regs;
		t_clocks;
		t_t2_source;
		t_wide;
		t_split;
		test_done;
	end
endmodule
`default_nettype wire
